/* File: logic/fpdi_pkg.sv */
/*
 * constants, field layouts, states and the ram request carrier of the
 * flash routine download and initialisation sequencer.
 * assumes a 40 MHz cpu clock and byte-wide ram and boot rom ports.
 */
package fpdi_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int DL_BYTES = 2048;
	localparam int IDX_W = 11;
	localparam int ADDR_W = 24;
	localparam int SEL_W = 4;
	localparam int SEL_IDX_W = 2;
	localparam int ROM_ADDR_W = SEL_IDX_W + IDX_W;
	localparam logic [IDX_W-1:0] IDX_LAST = 11'h7FF;
	localparam logic [SEL_W-1:0] ROUTINE_MAPPED = 4'h3;
	localparam logic [7:0] KEY_UNLOCK = 8'hA5;
	localparam logic [7:0] RESULT_PRELOAD = 8'hFF;
	localparam int RES_SS = 2;
	localparam int RES_FK = 1;
	localparam int RES_SF = 0;
	localparam logic [4:0] RES_UPPER_ZERO = 5'h00;
	localparam int FREQ_W = 16;
	localparam logic [31:0] BRANCH_NONE = 32'h00000000;
	localparam int STACK_LIMIT_BYTES = 128;
	localparam int BRANCH_INTERVAL_NS = 100000;
	localparam int BRANCH_CYCLES = BRANCH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int BR_CNT_W = 12;
	localparam logic [BR_CNT_W-1:0] BRANCH_LAST =
		BR_CNT_W'(BRANCH_CYCLES - 1);

	typedef struct packed {
		logic we;
		logic re;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} fpdi_ram_req_t;

	typedef enum {
		ST_IDLE,
		ST_CHECK,
		ST_CP_RD,
		ST_CP_WR,
		ST_VF_RD,
		ST_VF_WAIT,
		ST_VF_CMP,
		ST_RESULT
	} fpdi_state_t;
endpackage

/* File: logic/fpdi_download_init.sv */
/*
 * download sequencer: copies the selected built-in routine into ram,
 * reads it back, writes the result byte; also holds the initialisation
 * parameters and paces the user branch calls.
 * assumes boot rom and ram answer reads one cycle after the address.
 */
// Operation
// - writing 1 to the start bit copies the selected routine by itself.
// - the copy fills 2 kbytes of ram from the destination address.
// - the outcome goes to the first destination byte, bits 7..3 zero.
// - bit 2 is set for no, several or an unmapped routine selected.
// - bit 1 is 0 only when the unlock key register holds A5.
// - the copied routine is read back; bit 0 is 0 on match, 1 otherwise.
// - initialisation takes the cpu frequency used for pulse timing.
// - the branch parameter is a 32-bit address, zero meaning no branch.
// - the routine calls the branch at fixed intervals; code returns.
// - routines keep all cpu registers but the result byte, 128 b stack.
`timescale 1ns/1ps
module fpdi_download_init (
	input wire logic clk,
	input wire logic rst,
	input wire logic start_we,
	input wire logic start_wdata,
	input wire logic [fpdi_pkg::SEL_W-1:0] routine_select,
	input wire logic [7:0] flash_unlock_key_reg,
	input wire logic [fpdi_pkg::ADDR_W-1:0] download_dest_addr_reg,
	output logic [fpdi_pkg::ROM_ADDR_W-1:0] rom_addr,
	input wire logic [7:0] rom_rdata,
	output fpdi_pkg::fpdi_ram_req_t ram_req,
	input wire logic [7:0] ram_rdata,
	output logic download_start_bit,
	output logic download_done,
	output logic [7:0] cpu_result_low_byte,
	input wire logic init_start,
	input wire logic [31:0] cpu_general_reg_zero,
	input wire logic [31:0] cpu_general_reg_one,
	output logic [fpdi_pkg::FREQ_W-1:0] frequency_code_field,
	output logic [31:0] branch_address_field,
	output logic user_branch_enable,
	input wire logic pe_active,
	output logic branch_call
);
	fpdi_pkg::fpdi_state_t state, next_state;
	logic [fpdi_pkg::IDX_W-1:0] idx, next_idx;
	logic [fpdi_pkg::SEL_IDX_W-1:0] sel, next_sel;
	logic ss_err, next_ss_err;
	logic fk_err, next_fk_err;
	logic vf_err, next_vf_err;
	fpdi_pkg::fpdi_ram_req_t next_ram_req;
	logic next_done;
	logic [7:0] next_result;
	logic sel_bad;
	logic [fpdi_pkg::SEL_IDX_W-1:0] sel_enc;
	logic [fpdi_pkg::ADDR_W-1:0] byte_addr;

	// exactly one mapped routine is legal
	always_comb begin
		sel_bad = ($countones(routine_select) != 1) ||
			((routine_select & ~fpdi_pkg::ROUTINE_MAPPED) != '0);
		sel_enc = '0;
		for (int i = 0; i < fpdi_pkg::SEL_W; i++) begin
			if (routine_select[i]) begin
				sel_enc = fpdi_pkg::SEL_IDX_W'(i);
			end
		end
	end

	assign byte_addr = download_dest_addr_reg +
		fpdi_pkg::ADDR_W'(idx);
	assign rom_addr = {sel, idx};
	assign download_start_bit = (state != fpdi_pkg::ST_IDLE);

	always_comb begin
		next_state = state;
		next_idx = idx;
		next_sel = sel;
		next_ss_err = ss_err;
		next_fk_err = fk_err;
		next_vf_err = vf_err;
		next_ram_req = '0;
		next_done = 1'b0;
		next_result = cpu_result_low_byte;
		case (state)
			fpdi_pkg::ST_IDLE: begin
				if (start_we && start_wdata) begin
					next_state = fpdi_pkg::ST_CHECK;
				end
			end
			fpdi_pkg::ST_CHECK: begin
				next_ss_err = sel_bad;
				next_fk_err = (flash_unlock_key_reg !=
					fpdi_pkg::KEY_UNLOCK);
				next_sel = sel_enc;
				next_idx = '0;
				next_vf_err = 1'b0;
				if (sel_bad || (flash_unlock_key_reg !=
						fpdi_pkg::KEY_UNLOCK)) begin
					// nothing copied, so nothing can verify
					next_vf_err = 1'b1;
					next_state = fpdi_pkg::ST_RESULT;
				end else begin
					next_state = fpdi_pkg::ST_CP_RD;
				end
			end
			fpdi_pkg::ST_CP_RD: begin
				next_state = fpdi_pkg::ST_CP_WR;
			end
			fpdi_pkg::ST_CP_WR: begin
				next_ram_req.we = 1'b1;
				next_ram_req.addr = byte_addr;
				next_ram_req.wdata = rom_rdata;
				next_idx = idx + 1'b1;
				next_state = (idx == fpdi_pkg::IDX_LAST) ?
					fpdi_pkg::ST_VF_RD : fpdi_pkg::ST_CP_RD;
			end
			fpdi_pkg::ST_VF_RD: begin
				next_ram_req.re = 1'b1;
				next_ram_req.addr = byte_addr;
				next_state = fpdi_pkg::ST_VF_WAIT;
			end
			fpdi_pkg::ST_VF_WAIT: begin
				next_state = fpdi_pkg::ST_VF_CMP;
			end
			fpdi_pkg::ST_VF_CMP: begin
				if (ram_rdata != rom_rdata) begin
					next_vf_err = 1'b1;
				end
				next_idx = idx + 1'b1;
				next_state = (idx == fpdi_pkg::IDX_LAST) ?
					fpdi_pkg::ST_RESULT : fpdi_pkg::ST_VF_RD;
			end
			fpdi_pkg::ST_RESULT: begin
				// written last, over the first copied byte, so that byte ends up holding the outcome
				next_result = {fpdi_pkg::RES_UPPER_ZERO, ss_err, fk_err,
					vf_err};
				next_ram_req.we = 1'b1;
				next_ram_req.addr = download_dest_addr_reg;
				next_ram_req.wdata = next_result;
				next_done = 1'b1;
				next_state = fpdi_pkg::ST_IDLE;
			end
			default: begin
				next_state = fpdi_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= fpdi_pkg::ST_IDLE;
			idx <= '0;
			sel <= '0;
			ss_err <= 1'b0;
			fk_err <= 1'b0;
			vf_err <= 1'b0;
			ram_req <= '0;
			download_done <= 1'b0;
			cpu_result_low_byte <= '0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			sel <= next_sel;
			ss_err <= next_ss_err;
			fk_err <= next_fk_err;
			vf_err <= next_vf_err;
			ram_req <= next_ram_req;
			download_done <= next_done;
			cpu_result_low_byte <= next_result;
		end
	end

	// initialisation parameters and user branch pacing
	logic [fpdi_pkg::FREQ_W-1:0] next_freq;
	logic [31:0] next_branch;
	logic [fpdi_pkg::BR_CNT_W-1:0] br_cnt, next_br_cnt;
	logic next_call;

	always_comb begin
		next_freq = frequency_code_field;
		next_branch = branch_address_field;
		next_br_cnt = '0;
		next_call = 1'b0;
		if (init_start) begin
			// upper half ignored; software keeps it zero
			next_freq = cpu_general_reg_zero[fpdi_pkg::FREQ_W-1:0];
			next_branch = cpu_general_reg_one;
		end
		if (pe_active && user_branch_enable) begin
			if (br_cnt == fpdi_pkg::BRANCH_LAST) begin
				next_call = 1'b1;
			end else begin
				next_br_cnt = br_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frequency_code_field <= '0;
			branch_address_field <= fpdi_pkg::BRANCH_NONE;
			user_branch_enable <= 1'b0;
			br_cnt <= '0;
			branch_call <= 1'b0;
		end else begin
			frequency_code_field <= next_freq;
			branch_address_field <= next_branch;
			user_branch_enable <= (next_branch != fpdi_pkg::BRANCH_NONE);
			br_cnt <= next_br_cnt;
			branch_call <= next_call;
		end
	end

	res_upper_a: assert property (@(posedge clk) disable iff (rst)
		download_done |-> cpu_result_low_byte[7:3] == fpdi_pkg::RES_UPPER_ZERO)
		else $error("result upper bits not zero");
	start_taken_a: assert property (@(posedge clk) disable iff (rst)
		(state == fpdi_pkg::ST_IDLE && start_we && start_wdata)
		|=> download_start_bit)
		else $error("start write not taken");
	sel_err_a: assert property (@(posedge clk) disable iff (rst)
		(state == fpdi_pkg::ST_CHECK) |=> ss_err == $past(sel_bad))
		else $error("selection error wrong");
	key_err_a: assert property (@(posedge clk) disable iff (rst)
		(state == fpdi_pkg::ST_CHECK && flash_unlock_key_reg ==
		fpdi_pkg::KEY_UNLOCK) |=> !fk_err)
		else $error("key error with unlock key");
	dest_window_a: assert property (@(posedge clk) disable iff (rst)
		ram_req.we |-> (ram_req.addr - download_dest_addr_reg) <
		fpdi_pkg::ADDR_W'(fpdi_pkg::DL_BYTES))
		else $error("write outside destination");
	verify_fail_a: assert property (@(posedge clk) disable iff (rst)
		(state == fpdi_pkg::ST_VF_CMP && ram_rdata != rom_rdata)
		|=> vf_err)
		else $error("mismatch not flagged");
	result_last_a: assert property (@(posedge clk) disable iff (rst)
		download_done |-> ram_req.we && ram_req.addr ==
		download_dest_addr_reg && !download_start_bit)
		else $error("result write out of place");
	branch_off_a: assert property (@(posedge clk) disable iff (rst)
		(branch_address_field == fpdi_pkg::BRANCH_NONE) |-> ##1 !branch_call)
		else $error("branch call with zero target");
	freq_load_a: assert property (@(posedge clk) disable iff (rst)
		init_start |=> frequency_code_field ==
		$past(cpu_general_reg_zero[fpdi_pkg::FREQ_W-1:0]))
		else $error("frequency not loaded");
endmodule // fpdi_download_init

/* File: sim/fpdi_mem_model.sv */
/*
 * boot rom and ram model for the download sequencer.
 * assumes byte ports answering one cycle after the request.
 */
`timescale 1ns/1ps
module fpdi_mem_model (
	input wire logic clk,
	input wire logic [fpdi_pkg::ROM_ADDR_W-1:0] rom_addr,
	output logic [7:0] rom_rdata,
	input wire fpdi_pkg::fpdi_ram_req_t ram_req,
	output logic [7:0] ram_rdata,
	input wire logic corrupt
);
	logic [7:0] mem [0:4095];
	initial begin
		ram_rdata = 8'h00;
	end
	always @(posedge clk) begin
		rom_rdata <= rom_addr[7:0] ^ {rom_addr[12:11], rom_addr[10:5]};
		if (ram_req.we) begin
			mem[ram_req.addr[11:0]] <= ram_req.wdata;
		end
		// corrupt only when a scenario asks for a failed read-back
		if (ram_req.re) begin
			ram_rdata <= mem[ram_req.addr[11:0]] ^ {8{corrupt}};
		end else begin
			ram_rdata <= ~ram_rdata; // stale data never looks valid
		end
	end
endmodule // fpdi_mem_model

/* File: sim/flash_program_download_init_tb.sv */
/*
 * self-checking bench of the download sequencer.
 * assumes the memory model holds the ram the routine lands in.
 */
`timescale 1ns/1ps
module flash_program_download_init_tb;
	logic clk = 0, rst = 1, start_we = 0, start_wdata = 0, corrupt = 0;
	logic init_start = 0, pe_active = 0;
	logic [3:0] sel = 0;
	logic [7:0] key = 0, rom_rdata, ram_rdata, res;
	logic [23:0] dest = 0;
	logic [31:0] gr0 = 0, gr1 = 0, baddr;
	logic [12:0] rom_addr;
	fpdi_pkg::fpdi_ram_req_t ram_req;
	logic busy, done, ube, bcall;
	logic [15:0] freq;
	int bad_count = 0, checks_done = 0, n, j;
	logic [3:0] sels [7] = '{4'h1, 4'h2, 4'h0, 4'h3, 4'h4, 4'h8, 4'hF};
	always #12.5 clk = ~clk;
	fpdi_download_init u_fpdi_download_init (.clk(clk), .rst(rst),
		.start_we(start_we), .start_wdata(start_wdata),
		.routine_select(sel), .flash_unlock_key_reg(key),
		.download_dest_addr_reg(dest), .rom_addr(rom_addr),
		.rom_rdata(rom_rdata), .ram_req(ram_req), .ram_rdata(ram_rdata),
		.download_start_bit(busy), .download_done(done),
		.cpu_result_low_byte(res), .init_start(init_start),
		.cpu_general_reg_zero(gr0), .cpu_general_reg_one(gr1),
		.frequency_code_field(freq), .branch_address_field(baddr),
		.user_branch_enable(ube), .pe_active(pe_active),
		.branch_call(bcall));
	fpdi_mem_model u_fpdi_mem_model (.clk(clk), .rom_addr(rom_addr),
		.rom_rdata(rom_rdata), .ram_req(ram_req), .ram_rdata(ram_rdata),
		.corrupt(corrupt));
	task final_report;
		if (bad_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	function logic [7:0] rom_b(input logic [12:0] a);
		return a[7:0] ^ {a[12:11], a[10:5]};
	endfunction
	function logic [7:0] exp_res(input logic [3:0] s, input logic [7:0] k,
		input logic c);
		logic ss, fk;
		ss = !(s == 4'h1 || s == 4'h2);
		fk = k !== 8'hA5;
		return {5'h00, ss, fk, ss | fk | c};
	endfunction
	// called at a falling edge; poke tries a refused start mid-copy
	task run_dl(input logic [3:0] s, input logic [7:0] k, input logic c,
		input logic poke);
		logic [7:0] r;
		logic ok;
		sel = s;
		key = k;
		corrupt = c;
		dest = {12'($urandom), 12'h000};
		for (int i = 0; i < 4096; i++) u_fpdi_mem_model.mem[i] = 8'h5A;
		u_fpdi_mem_model.mem[0] = 8'hFF;
		r = exp_res(s, k, c);
		ok = !(r[2] | r[1]);
		start_we = 1;
		start_wdata = 1;
		n = 0;
		while (n < 12000) begin
			@(negedge clk);
			n++;
			start_we = poke && n == 5;
			if (n == 1) chk(busy, 1);
			if (done === 1'b1) break;
		end
		if (n == 12000) begin
			bad_count++;
			final_report;
		end
		chk(n, ok ? 10243 : 3);
		chk(res, r);
		// result write is registered with done; ram takes it one edge later
		@(negedge clk);
		chk(u_fpdi_mem_model.mem[0], r);
		chk(busy, 0);
		if (ok) begin
			for (int i = 1; i < 2048; i++)
				chk(u_fpdi_mem_model.mem[i], rom_b({s == 4'h2, 11'(i)}));
			chk(u_fpdi_mem_model.mem[2048], 8'h5A);
		end else chk(u_fpdi_mem_model.mem[1], 8'h5A);
	endtask
	task do_init(input logic [31:0] a);
		gr0 = {16'h0000, 16'h0FA0};
		gr1 = a;
		init_start = 1;
		@(negedge clk);
		init_start = 0;
		chk(freq, 16'h0FA0);
		chk(baddr, a);
		chk(ube, a != 0);
	endtask
	initial begin
		void'($urandom(39));
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 0;
		chk({res, busy, done, bcall}, 0);
		start_we = 1;
		@(negedge clk);
		start_we = 0;
		@(negedge clk);
		chk(busy, 0);
		foreach (sels[i]) run_dl(sels[i], 8'hA5, 0, 0);
		key = 8'($urandom);
		run_dl(4'h1, key == 8'hA5 ? 8'h5A : key, 0, 0);
		run_dl(4'h2, 8'hA5, 1, 1);
		run_dl(4'($urandom), 8'hA5, 0, 0);
		@(negedge clk);
		chk(done, 0);
		// branch target in ram just past the routine window
		do_init({8'h00, dest + 24'h000800});
		// no download or init is started while the branch runs
		pe_active = 1;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (bcall !== 1'b1 && n < 5000);
			if (bcall !== 1'b1) begin
				bad_count++;
				final_report;
			end
			chk(n, 4000);
		end
		pe_active = 0;
		do_init(32'h00000000);
		pe_active = 1;
		j = 0;
		repeat (4100) begin
			@(negedge clk);
			j += (bcall !== 1'b0);
		end
		chk(j, 0);
		final_report;
	end
endmodule // flash_program_download_init_tb
